// ==== verilog/intr_pkg.sv ====
`default_nettype none
package intr_pkg;

    ////////////////////////////////////////
    // Register indices on the plain register port
    localparam logic [2:0] RESET_CAUSE_CONTROL_IDX     = 3'h0;
    localparam logic [2:0] MAIN_INTERRUPT_CONTROL_IDX  = 3'h1;
    localparam logic [2:0] INTERRUPT_CONTROL_TWO_IDX   = 3'h2;
    localparam logic [2:0] INTERRUPT_CONTROL_THREE_IDX = 3'h3;
    localparam logic [2:0] TIMER_MODE_CONTROL_IDX      = 3'h4;

    ////////////////////////////////////////
    // Reset cause and control fields
    localparam int PRIORITY_LEVELS_ENABLE_BIT   = 7;
    localparam int SOFTWARE_BROWNOUT_ENABLE_BIT = 6;
    localparam int UNUSED_CAUSE_BIT             = 5;
    localparam int RESET_INSTRUCTION_FLAG_BIT   = 4;
    localparam int WATCHDOG_TIMEOUT_FLAG_BIT    = 3;
    localparam int POWER_DOWN_FLAG_BIT          = 2;
    localparam int POWER_ON_STATUS_BIT          = 1;
    localparam int BROWNOUT_STATUS_BIT          = 0;
    localparam logic [7:0] RESET_CAUSE_RESET    = 8'h5C;
    localparam logic [7:0] RESET_CAUSE_WR_MASK  = 8'hD3;

    ////////////////////////////////////////
    // Main interrupt control fields
    localparam int GLOBAL_INTERRUPT_ENABLE_BIT = 7;
    localparam int LOW_INTERRUPT_ENABLE_BIT    = 6;
    localparam int TIMER_OVERFLOW_ENABLE_BIT   = 5;
    localparam int EXTERNAL_ZERO_ENABLE_BIT    = 4;
    localparam int PORT_CHANGE_ENABLE_BIT      = 3;
    localparam int TIMER_OVERFLOW_FLAG_BIT     = 2;
    localparam int EXTERNAL_ZERO_FLAG_BIT      = 1;
    localparam int PORT_CHANGE_FLAG_BIT        = 0;
    localparam logic [7:0] MAIN_CONTROL_RESET  = 8'h00;

    ////////////////////////////////////////
    // Interrupt control two fields
    localparam int EDGE_ZERO_SELECT_BIT         = 7;
    localparam int EDGE_ONE_SELECT_BIT          = 6;
    localparam int EDGE_TWO_SELECT_BIT          = 5;
    localparam int TIMER_OVERFLOW_PRIORITY_BIT  = 2;
    localparam int PORT_CHANGE_PRIORITY_BIT     = 0;
    localparam logic [7:0] CONTROL_TWO_RESET    = 8'hE5;
    localparam logic [7:0] CONTROL_TWO_WR_MASK  = 8'hE5;

    ////////////////////////////////////////
    // Interrupt control three fields
    localparam int EXTERNAL_TWO_PRIORITY_BIT     = 7;
    localparam int EXTERNAL_ONE_PRIORITY_BIT     = 6;
    localparam int EXTERNAL_TWO_ENABLE_BIT       = 4;
    localparam int EXTERNAL_ONE_ENABLE_BIT       = 3;
    localparam int EXTERNAL_TWO_FLAG_BIT         = 1;
    localparam int EXTERNAL_ONE_FLAG_BIT         = 0;
    localparam logic [7:0] CONTROL_THREE_RESET   = 8'hC0;
    localparam logic [7:0] CONTROL_THREE_WR_MASK = 8'hDB;

    ////////////////////////////////////////
    // Timer mode control and sizes
    localparam int TIMER_WIDE_MODE_BIT          = 0;
    localparam logic [15:0] TIMER_ALL_ONES      = 16'hFFFF;
    localparam int EXTERNAL_PIN_COUNT           = 3;
    localparam int WATCHED_PORT_WIDTH           = 4;
    localparam int RETURN_STACK_DEPTH           = 31;
    localparam int PROGRAM_COUNTER_WIDTH        = 21;

endpackage
`default_nettype wire

// ==== verilog/input_filter.sv ====
`timescale 1ns/1ps
`default_nettype none
module input_filter
#(
    parameter int WIDTH = 7
)
(
    input  wire logic             sys_clk_in,
    input  wire logic             sys_rst_in,
    input  wire logic [WIDTH-1:0] raw_in,
    output logic      [WIDTH-1:0] stable_out,
    output logic      [WIDTH-1:0] change_out
);

    typedef struct packed {
        logic [WIDTH-1:0] stage_one;
        logic [WIDTH-1:0] stage_two;
        logic [WIDTH-1:0] stage_three;
        logic [WIDTH-1:0] stable;
        logic [WIDTH-1:0] change;
    } filter_state_type;

    filter_state_type st;
    filter_state_type next_st;

    ////////////////////////////////////////
    // Three stage capture; a level counts once stages two and three agree
    always_comb
    begin
        next_st = st;
        next_st.stage_one = raw_in;
        next_st.stage_two = st.stage_one;
        next_st.stage_three = st.stage_two;
        for (int i = 0; i < WIDTH; i++)
        begin
            next_st.change[i] = 1'b0;
            if ((st.stage_two[i] == st.stage_three[i]) && (st.stage_three[i] != st.stable[i]))
            begin
                next_st.stable[i] = st.stage_three[i];
                next_st.change[i] = 1'b1;
            end
        end
        if (sys_rst_in)
        begin
            next_st = '0;
        end
    end

    // State register
    always_ff @(posedge sys_clk_in)
    begin
        st <= next_st;
    end

    assign stable_out = st.stable;
    assign change_out = st.change;

endmodule
`default_nettype wire

// ==== verilog/interrupt_sources_priority.sv ====
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module interrupt_sources_priority
#(
    parameter int STACK_DEPTH = intr_pkg::RETURN_STACK_DEPTH,
    parameter int PC_WIDTH    = intr_pkg::PROGRAM_COUNTER_WIDTH
)
(
    input  wire logic                sys_clk_in,
    input  wire logic                sys_rst_in,
    input  wire logic [2:0]          reg_addr_in,
    input  wire logic [7:0]          reg_wdata_in,
    input  wire logic                reg_write_in,
    input  wire logic                reg_read_in,
    output logic      [7:0]          reg_rdata_out,
    input  wire logic [2:0]          external_pin_in,
    input  wire logic [3:0]          watched_port_in,
    input  wire logic [15:0]         timer_count_pair_in,
    input  wire logic                sleep_enter_in,
    input  wire logic                watchdog_timeout_in,
    input  wire logic                watchdog_clear_in,
    input  wire logic                reset_instruction_in,
    input  wire logic                interrupt_ack_in,
    input  wire logic                interrupt_return_in,
    input  wire logic [PC_WIDTH-1:0] return_pc_in,
    input  wire logic [7:0]          working_register_in,
    input  wire logic [7:0]          status_in,
    input  wire logic [7:0]          bank_select_register_in,
    output logic                     irq_high_out,
    output logic                     irq_low_out,
    output logic                     wake_out,
    output logic                     wake_vector_out,
    output logic [PC_WIDTH-1:0]      return_pc_out,
    output logic [7:0]               shadow_working_out,
    output logic [7:0]               shadow_status_out,
    output logic [7:0]               shadow_bank_select_out,
    output logic                     stack_error_out,
    output logic                     priority_levels_enable_out,
    output logic                     software_brownout_enable_out
);

    localparam int SP_WIDTH = $clog2(STACK_DEPTH + 1);
    localparam logic [SP_WIDTH-1:0] STACK_FULL = SP_WIDTH'(STACK_DEPTH);
    localparam logic [SP_WIDTH-1:0] SP_ONE     = SP_WIDTH'(1);
    localparam int FILTER_WIDTH = intr_pkg::EXTERNAL_PIN_COUNT + intr_pkg::WATCHED_PORT_WIDTH;

    typedef struct packed {
        logic [7:0]                             reset_cause_control;
        logic [7:0]                             main_interrupt_control;
        logic [7:0]                             interrupt_control_two;
        logic [7:0]                             interrupt_control_three;
        logic                                   timer_wide_mode;
        logic [15:0]                            prev_count;
        logic                                   sleeping;
        logic [2:0]                             wake_enable_snapshot;
        logic                                   wake;
        logic                                   wake_vector;
        logic                                   irq_high;
        logic                                   irq_low;
        logic [7:0]                             rdata;
        logic [STACK_DEPTH-1:0][PC_WIDTH-1:0]   stack;
        logic [SP_WIDTH-1:0]                    sp;
        logic [PC_WIDTH-1:0]                    return_pc;
        logic [7:0]                             shadow_working;
        logic [7:0]                             shadow_status;
        logic [7:0]                             shadow_bank_select;
        logic                                   stack_error;
    } core_state_type;

    core_state_type st;
    core_state_type next_st;

    logic [FILTER_WIDTH-1:0] filt_stable;
    logic [FILTER_WIDTH-1:0] filt_change;

    ////////////////////////////////////////
    // Wrap detection for eight or sixteen bit timer counts
    function automatic logic timer_wrapped(input logic [15:0] prev, input logic [15:0] cur, input logic wide);
        logic result;
        result = 1'b0;
        if (wide)
        begin
            result = (prev == intr_pkg::TIMER_ALL_ONES) && (cur == 16'h0000);
        end
        else
        begin
            result = (prev[7:0] == intr_pkg::TIMER_ALL_ONES[7:0]) && (cur[7:0] == 8'h00);
        end
        return result;
    endfunction

    // Request for one vector level from active sources and their priorities
    function automatic logic level_request(input logic [4:0] active, input logic [4:0] prio, input logic high);
        logic result;
        result = high ? |(active & prio) : |(active & ~prio);
        return result;
    endfunction

    ////////////////////////////////////////
    // Pin and port synchronisers with change detection
    input_filter #(
        .WIDTH      (FILTER_WIDTH)
    ) u_filter (
        .sys_clk_in (sys_clk_in),
        .sys_rst_in (sys_rst_in),
        .raw_in     ({watched_port_in, external_pin_in}),
        .stable_out (filt_stable),
        .change_out (filt_change)
    );

    ////////////////////////////////////////
    // Next state
    always_comb
    begin
        logic [2:0] pin_edge;
        logic [2:0] polarity;
        logic       port_change;
        logic       overflow;
        logic [4:0] flags;
        logic [4:0] enables;
        logic [4:0] prio;
        logic [4:0] active;
        logic       priority_levels_enable;
        logic       global_interrupt_enable;
        logic       giel;
        logic [SP_WIDTH-1:0] top;
        pin_edge = 3'b000;
        polarity = 3'b000;
        port_change = 1'b0;
        overflow = 1'b0;
        flags = 5'b00000;
        enables = 5'b00000;
        prio = 5'b00000;
        active = 5'b00000;
        priority_levels_enable = 1'b0;
        global_interrupt_enable = 1'b0;
        giel = 1'b0;
        top = '0;
        next_st = st;

        // Register read data, valid the cycle after the strobe
        next_st.rdata = 8'h00;
        if (reg_read_in)
        begin
            case (reg_addr_in)
                intr_pkg::RESET_CAUSE_CONTROL_IDX:
                begin
                    next_st.rdata = st.reset_cause_control;
                    next_st.rdata[intr_pkg::UNUSED_CAUSE_BIT] = 1'b0;
                end
                intr_pkg::MAIN_INTERRUPT_CONTROL_IDX:  next_st.rdata = st.main_interrupt_control;
                intr_pkg::INTERRUPT_CONTROL_TWO_IDX:   next_st.rdata = st.interrupt_control_two;
                intr_pkg::INTERRUPT_CONTROL_THREE_IDX: next_st.rdata = st.interrupt_control_three;
                intr_pkg::TIMER_MODE_CONTROL_IDX:      next_st.rdata = {7'h00, st.timer_wide_mode};
                default:                               next_st.rdata = 8'h00;
            endcase
        end

        // Register writes; read-only cause bits are masked off
        if (reg_write_in)
        begin
            case (reg_addr_in)
                intr_pkg::RESET_CAUSE_CONTROL_IDX:
                begin
                    next_st.reset_cause_control = (st.reset_cause_control & ~intr_pkg::RESET_CAUSE_WR_MASK)
                        | (reg_wdata_in & intr_pkg::RESET_CAUSE_WR_MASK);
                end
                intr_pkg::MAIN_INTERRUPT_CONTROL_IDX:  next_st.main_interrupt_control = reg_wdata_in;
                intr_pkg::INTERRUPT_CONTROL_TWO_IDX:
                begin
                    next_st.interrupt_control_two = reg_wdata_in & intr_pkg::CONTROL_TWO_WR_MASK;
                end
                intr_pkg::INTERRUPT_CONTROL_THREE_IDX:
                begin
                    next_st.interrupt_control_three = reg_wdata_in & intr_pkg::CONTROL_THREE_WR_MASK;
                end
                intr_pkg::TIMER_MODE_CONTROL_IDX:
                begin
                    next_st.timer_wide_mode = reg_wdata_in[intr_pkg::TIMER_WIDE_MODE_BIT];
                end
                default:
                begin
                    next_st.timer_wide_mode = st.timer_wide_mode;
                end
            endcase
        end

        // Hardware updates of reset cause flags
        if (watchdog_clear_in)
        begin
            next_st.reset_cause_control[intr_pkg::WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b1;
            next_st.reset_cause_control[intr_pkg::POWER_DOWN_FLAG_BIT] = 1'b1;
        end
        if (sleep_enter_in)
        begin
            next_st.reset_cause_control[intr_pkg::POWER_DOWN_FLAG_BIT] = 1'b0;
        end
        if (watchdog_timeout_in)
        begin
            next_st.reset_cause_control[intr_pkg::WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b0;
        end
        if (reset_instruction_in)
        begin
            next_st.reset_cause_control[intr_pkg::RESET_INSTRUCTION_FLAG_BIT] = 1'b0;
        end

        // Edge events on the external pins, polarity per pin
        polarity = {st.interrupt_control_two[intr_pkg::EDGE_TWO_SELECT_BIT],
                    st.interrupt_control_two[intr_pkg::EDGE_ONE_SELECT_BIT],
                    st.interrupt_control_two[intr_pkg::EDGE_ZERO_SELECT_BIT]};
        for (int i = 0; i < intr_pkg::EXTERNAL_PIN_COUNT; i++)
        begin
            pin_edge[i] = filt_change[i] && (filt_stable[i] == polarity[i]);
        end
        port_change = |filt_change[FILTER_WIDTH-1:intr_pkg::EXTERNAL_PIN_COUNT];
        overflow = timer_wrapped(st.prev_count, timer_count_pair_in, st.timer_wide_mode);
        next_st.prev_count = timer_count_pair_in;

        // Flags set by events after the software write so a set wins
        if (pin_edge[0])
        begin
            next_st.main_interrupt_control[intr_pkg::EXTERNAL_ZERO_FLAG_BIT] = 1'b1;
        end
        if (pin_edge[1])
        begin
            next_st.interrupt_control_three[intr_pkg::EXTERNAL_ONE_FLAG_BIT] = 1'b1;
        end
        if (pin_edge[2])
        begin
            next_st.interrupt_control_three[intr_pkg::EXTERNAL_TWO_FLAG_BIT] = 1'b1;
        end
        if (overflow)
        begin
            next_st.main_interrupt_control[intr_pkg::TIMER_OVERFLOW_FLAG_BIT] = 1'b1;
        end
        if (port_change)
        begin
            next_st.main_interrupt_control[intr_pkg::PORT_CHANGE_FLAG_BIT] = 1'b1;
        end

        // Source vectors: pin zero, pin one, pin two, timer, port change
        flags = {st.main_interrupt_control[intr_pkg::PORT_CHANGE_FLAG_BIT],
                 st.main_interrupt_control[intr_pkg::TIMER_OVERFLOW_FLAG_BIT],
                 st.interrupt_control_three[intr_pkg::EXTERNAL_TWO_FLAG_BIT],
                 st.interrupt_control_three[intr_pkg::EXTERNAL_ONE_FLAG_BIT],
                 st.main_interrupt_control[intr_pkg::EXTERNAL_ZERO_FLAG_BIT]};
        enables = {st.main_interrupt_control[intr_pkg::PORT_CHANGE_ENABLE_BIT],
                   st.main_interrupt_control[intr_pkg::TIMER_OVERFLOW_ENABLE_BIT],
                   st.interrupt_control_three[intr_pkg::EXTERNAL_TWO_ENABLE_BIT],
                   st.interrupt_control_three[intr_pkg::EXTERNAL_ONE_ENABLE_BIT],
                   st.main_interrupt_control[intr_pkg::EXTERNAL_ZERO_ENABLE_BIT]};
        prio = {st.interrupt_control_two[intr_pkg::PORT_CHANGE_PRIORITY_BIT],
                st.interrupt_control_two[intr_pkg::TIMER_OVERFLOW_PRIORITY_BIT],
                st.interrupt_control_three[intr_pkg::EXTERNAL_TWO_PRIORITY_BIT],
                st.interrupt_control_three[intr_pkg::EXTERNAL_ONE_PRIORITY_BIT],
                1'b1};
        active = flags & enables;
        priority_levels_enable = st.reset_cause_control[intr_pkg::PRIORITY_LEVELS_ENABLE_BIT];
        global_interrupt_enable = st.main_interrupt_control[intr_pkg::GLOBAL_INTERRUPT_ENABLE_BIT];
        giel = st.main_interrupt_control[intr_pkg::LOW_INTERRUPT_ENABLE_BIT];

        // Request levels; single level mode ignores priority bits
        if (priority_levels_enable)
        begin
            next_st.irq_high = global_interrupt_enable && level_request(active, prio, 1'b1);
            next_st.irq_low = global_interrupt_enable && giel && level_request(active, prio, 1'b0);
        end
        else
        begin
            next_st.irq_high = global_interrupt_enable && (|active);
            next_st.irq_low = 1'b0;
        end

        // Sleep entry snapshots pin enables; wake on a pin edge so enabled
        next_st.wake = 1'b0;
        if (sleep_enter_in)
        begin
            next_st.sleeping = 1'b1;
            next_st.wake_enable_snapshot = enables[2:0];
        end
        else if (st.sleeping && (|(pin_edge & st.wake_enable_snapshot)))
        begin
            next_st.sleeping = 1'b0;
            next_st.wake = 1'b1;
            next_st.wake_vector = global_interrupt_enable;
        end

        // Interrupt entry saves return address and fast shadow copy
        if (interrupt_ack_in)
        begin
            next_st.shadow_working = working_register_in;
            next_st.shadow_status = status_in;
            next_st.shadow_bank_select = bank_select_register_in;
            if (st.sp < STACK_FULL)
            begin
                next_st.stack[st.sp] = return_pc_in;
                next_st.sp = st.sp + SP_ONE;
            end
            else
            begin
                next_st.stack_error = 1'b1;
            end
        end
        else if (interrupt_return_in)
        begin
            if (st.sp != '0)
            begin
                top = st.sp - SP_ONE;
                next_st.return_pc = st.stack[top];
                next_st.sp = top;
            end
            else
            begin
                next_st.stack_error = 1'b1;
            end
        end

        // Synchronous reset to documented values
        if (sys_rst_in)
        begin
            next_st = '0;
            next_st.reset_cause_control = intr_pkg::RESET_CAUSE_RESET;
            next_st.main_interrupt_control = intr_pkg::MAIN_CONTROL_RESET;
            next_st.interrupt_control_two = intr_pkg::CONTROL_TWO_RESET;
            next_st.interrupt_control_three = intr_pkg::CONTROL_THREE_RESET;
        end
    end

    ////////////////////////////////////////
    // State register
    always_ff @(posedge sys_clk_in)
    begin
        st <= next_st;
    end

    ////////////////////////////////////////
    // Outputs straight from state
    assign reg_rdata_out = st.rdata;
    assign irq_high_out = st.irq_high;
    assign irq_low_out = st.irq_low;
    assign wake_out = st.wake;
    assign wake_vector_out = st.wake_vector;
    assign return_pc_out = st.return_pc;
    assign shadow_working_out = st.shadow_working;
    assign shadow_status_out = st.shadow_status;
    assign shadow_bank_select_out = st.shadow_bank_select;
    assign stack_error_out = st.stack_error;
    assign priority_levels_enable_out = st.reset_cause_control[intr_pkg::PRIORITY_LEVELS_ENABLE_BIT];
    assign software_brownout_enable_out = st.reset_cause_control[intr_pkg::SOFTWARE_BROWNOUT_ENABLE_BIT];

endmodule
`default_nettype wire

// ==== tb/isp_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module isp_assertions
#(
    parameter int PC_WIDTH = 21
)
(
    input wire logic                sys_clk_in,
    input wire logic                sys_rst_in,
    input wire logic [2:0]          reg_addr_in,
    input wire logic [7:0]          reg_wdata_in,
    input wire logic                reg_write_in,
    input wire logic                reg_read_in,
    input wire logic [7:0]          reg_rdata_out,
    input wire logic                interrupt_ack_in,
    input wire logic                interrupt_return_in,
    input wire logic [PC_WIDTH-1:0] return_pc_in,
    input wire logic [7:0]          working_register_in,
    input wire logic                irq_low_out,
    input wire logic                wake_out,
    input wire logic [PC_WIDTH-1:0] return_pc_out,
    input wire logic [7:0]          shadow_working_out,
    input wire logic                stack_error_out,
    input wire logic                priority_levels_enable_out
);
    ////////////////////////////////////////
    // One clock and one reset for all checks
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    // Entry followed at once by a return
    sequence s_push_pop;
        interrupt_ack_in ##1 (interrupt_return_in && !interrupt_ack_in);
    endsequence

    a_cause_bit_five: assert property ($past(reg_read_in && reg_addr_in == 3'h0) |-> !reg_rdata_out[5])
        else $error("cause bit five read as one");
    a_levels_follow: assert property ((reg_write_in && reg_addr_in == 3'h0) |-> ##2
        priority_levels_enable_out == $past(reg_wdata_in[7], 2)) else $error("levels enable not written");
    a_single_level: assert property ((!priority_levels_enable_out && $past(!priority_levels_enable_out))
        |-> !irq_low_out) else $error("low request with levels off");
    a_shadow_copy: assert property (interrupt_ack_in |=> shadow_working_out == $past(working_register_in))
        else $error("working shadow not copied");
    a_shadow_hold: assert property (!interrupt_ack_in |=> $stable(shadow_working_out))
        else $error("working shadow changed without entry");
    a_push_pop: assert property (s_push_pop |=> return_pc_out == $past(return_pc_in, 2))
        else $error("popped address differs from pushed");
    a_stack_sticky: assert property (stack_error_out |=> stack_error_out)
        else $error("stack error cleared");
    a_wake_pulse: assert property (wake_out |=> !wake_out)
        else $error("wake longer than one cycle");
endmodule
`default_nettype wire

// ==== tb/core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module core_model
(
    input  wire logic       sys_clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       irq_in,
    output var logic        ack_out = 1'b0,
    output var logic        ret_out = 1'b0,
    output var logic [20:0] pc_out = 21'h0_0100,
    output var logic [7:0]  working_register_out = 8'h5A,
    output var logic [7:0]  stat_out = 8'h00,
    output var logic [7:0]  bsr_out = 8'h00
);
    logic last = 1'b0;

    // Acks each new request, returns next cycle
    always @(posedge sys_clk_in)
    begin
        last <= irq_in;
        ack_out <= irq_in && !last && !sys_rst_in;
        ret_out <= ack_out;
        if (ack_out)
        begin
            pc_out <= pc_out + 21'h0_0001;
            working_register_out <= working_register_out + 8'h01;
            stat_out <= ~working_register_out;
            bsr_out <= working_register_out ^ 8'h0F;
        end
    end
endmodule
`default_nettype wire

// ==== tb/interrupt_sources_priority_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; \
    if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module interrupt_sources_priority_tb;
    logic        sys_clk_in = 1'b0, sys_rst_in = 1'b1, reg_write_in = 1'b0, reg_read_in = 1'b0;
    logic        sleep_enter_in = 1'b0, seen, interrupt_ack_in, interrupt_return_in;
    logic        irq_high_out, irq_low_out, wake_out, wake_vector_out, priority_levels_enable_out;
    logic [2:0]  reg_addr_in = 3'h0, external_pin_in = 3'h0;
    logic [3:0]  watched_port_in = 4'h0;
    logic [7:0]  reg_wdata_in = 8'h00, reg_rdata_out, v, working_register_in, status_in, bank_select_register_in;
    logic [15:0] timer_count_pair_in = 16'h0000;
    logic [20:0] return_pc_in;
    logic [7:0]  rst_tab [6] = '{8'h5C, 8'h00, 8'hE5, 8'hC0, 8'h00, 8'h00};
    int          num_errors = 0, total_checks = 0;

    always #50 sys_clk_in = ~sys_clk_in;

    interrupt_sources_priority interrupt_sources_priority_i (.sys_clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in,
        .reg_write_in, .reg_read_in, .reg_rdata_out, .external_pin_in, .watched_port_in, .timer_count_pair_in,
        .sleep_enter_in, .watchdog_timeout_in(1'b0), .watchdog_clear_in(1'b0), .reset_instruction_in(1'b0),
        .interrupt_ack_in, .interrupt_return_in, .return_pc_in, .working_register_in, .status_in,
        .bank_select_register_in, .irq_high_out, .irq_low_out, .wake_out, .wake_vector_out, .return_pc_out(),
        .shadow_working_out(), .shadow_status_out(), .shadow_bank_select_out(), .stack_error_out(),
        .priority_levels_enable_out, .software_brownout_enable_out());
    core_model core_model_i (.sys_clk_in, .sys_rst_in, .irq_in(irq_high_out | irq_low_out),
        .ack_out(interrupt_ack_in), .ret_out(interrupt_return_in), .pc_out(return_pc_in),
        .working_register_out(working_register_in), .stat_out(status_in), .bsr_out(bank_select_register_in));

    ////////////////////////////////////////
    // Register port cycles
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_write_in <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_read_in <= 1'b0;
        #1 v = reg_rdata_out;
    endtask
    // Wrong edge then valid edge on one pin, then request routing
    task automatic pin_case(input int n, input logic pol, input logic en, input logic lv);
        logic [2:0] a;
        int b;
        a = (n == 0) ? 3'h1 : 3'h3;
        b = (n == 0) ? 1 : n - 1;
        wr(3'h2, {pol, pol, pol, 5'h00});
        external_pin_in <= {3{pol}};
        repeat (8) @(posedge sys_clk_in);
        wr(3'h1, 8'hD0);
        wr(3'h3, {pol, pol, 1'b0, en, en, 3'h0});
        external_pin_in[n] <= ~pol;
        repeat (8) @(posedge sys_clk_in);
        rd(a);
        `CHK("wrong edge flag", 1'b0, v[b])
        external_pin_in[n] <= pol;
        repeat (7) @(posedge sys_clk_in);
        rd(a);
        `CHK("pin flag", 1'b1, v[b])
        `CHK("irq high", (lv ? (n == 0 || (en && pol)) : (n == 0 || en)), irq_high_out)
        `CHK("irq low", (lv && en && n != 0 && !pol), irq_low_out)
    endtask
    // Count jump from a to b, flag expected or not
    task automatic tmr(input logic [15:0] a, input logic [15:0] b, input logic e);
        wr(3'h1, 8'hD0);
        timer_count_pair_in <= a;
        repeat (2) @(posedge sys_clk_in);
        timer_count_pair_in <= b;
        repeat (3) @(posedge sys_clk_in);
        rd(3'h1);
        `CHK("timer flag", e, v[2])
    endtask
    // Sleep with pin one enable en3 at entry, then a valid edge
    task automatic nap(input logic [7:0] en3, input logic e);
        wr(3'h3, en3);
        @(posedge sys_clk_in) sleep_enter_in <= 1'b1;
        @(posedge sys_clk_in) sleep_enter_in <= 1'b0;
        wr(3'h3, 8'h08);
        external_pin_in[1] <= 1'b1;
        repeat (8) @(posedge sys_clk_in);
        external_pin_in[1] <= 1'b0;
        seen = 1'b0;
        repeat (10) @(posedge sys_clk_in) #1 seen |= (wake_out === 1'b1);
        `CHK("wake", e, seen)
        `CHK("wake vector", e, wake_vector_out)
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (10) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            rd(i[2:0]);
            `CHK("reset value", rst_tab[i], v)
        end
        wr(3'h0, 8'hFF);
        rd(3'h0);
        `CHK("cause write", 8'hDF, v)
        `CHK("levels out", 1'b1, priority_levels_enable_out)
        for (int p = 0; p < 2; p++)
            for (int n = 0; n < 3; n++)
                pin_case(n, p[0], 1'b1, 1'b1);
        pin_case(1, 1'b1, 1'b0, 1'b1);
        wr(3'h0, 8'h00);
        pin_case(2, 1'b0, 1'b1, 1'b0);
        tmr(16'h00FF, 16'h0100, 1'b1);
        wr(3'h4, 8'h01);
        tmr(16'h00FF, 16'h0100, 1'b0);
        tmr(16'hFFFF, 16'h0000, 1'b1);
        wr(3'h1, 8'hD0);
        watched_port_in <= 4'h8;
        repeat (7) @(posedge sys_clk_in);
        rd(3'h1);
        `CHK("port flag", 1'b1, v[0])
        nap(8'h00, 1'b0);
        nap(8'h08, 1'b1);
        report_and_stop();
    end
endmodule

bind interrupt_sources_priority isp_assertions #(.PC_WIDTH(PC_WIDTH)) isp_assertions_i (.*);
`default_nettype wire
